// File: haptic_motor_drive_control.sv
// Haptic actuator drive control: source select, squelch, slew, outputs, APB registers
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module haptic_motor_drive_control (
  input wire logic mclk_in, // 10 MHz clock
  input wire logic rst_in, // async reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic pwm_level_in, // pulse-width drive input
  input wire logic slow_osc_clock_in, // slow oscillator, sampled
  input wire logic short_detect_in, // driver over-current level
  output logic [7:0] dac_code_out, // signed code to converter
  output logic drive_out_pos_out, // drive positive terminal
  output logic drive_out_neg_out, // drive negative terminal
  output logic [1:0] drive_gain_out, // gain select to amplifier
  output logic drive_range_out, // drive range setting
  output logic driver_enable_out // analog driver enable
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic [15:0] ctrl;
    logic [7:0] amplitude;
    logic short_flag;
    logic osc_prev;
    logic [7:0] code;
    logic [9:0] sq_cnt;
    logic [7:0] level;
    logic phase;
    logic [7:0] dac;
    logic pos;
    logic neg;
    logic [31:0] rdata;
  } drv_state_t;

  drv_state_t st_reg;
  drv_state_t st_next;

  logic [7:0] dec_code;
  logic dec_evt;
  logic [1:0] load_type_enable;
  logic drive_source_select;
  logic [1:0] slew_bandwidth;
  logic [7:0] squelch_range;
  logic enabled;
  logic is_erm;
  logic is_lra;
  logic slow_tick;
  logic sample_evt;
  logic sq_evt;
  logic in_squelch;
  logic sq_active;
  logic [7:0] target;
  logic [8:0] diff;
  logic [8:0] step;
  logic [7:0] drive;
  logic access;
  logic mapped;

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] abs8(input logic [7:0] v);
    abs8 = v[7] ? (8'h00 - v) : v;
  endfunction : abs8

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == haptic_drive_pkg::CTRL_OFFSET) || (a == haptic_drive_pkg::AMP_OFFSET)
      || (a == haptic_drive_pkg::STATUS_OFFSET);
  endfunction : reg_hit

  pwm_duty_decode u_decode (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .pwm_level_in(pwm_level_in),
    .code_out(dec_code),
    .period_out(dec_evt)
  );

  // ==========================================================================
  // Mode decode
  always_comb begin
    load_type_enable = st_reg.ctrl[haptic_drive_pkg::LTE_LSB +: 2];
    drive_source_select = st_reg.ctrl[haptic_drive_pkg::SRC_BIT];
    slew_bandwidth = st_reg.ctrl[haptic_drive_pkg::BW_LSB +: 2];
    squelch_range = st_reg.ctrl[haptic_drive_pkg::SQ_LSB +: 8];
    enabled = (load_type_enable != haptic_drive_pkg::LOAD_OFF); // [R1]
    is_erm = (load_type_enable == haptic_drive_pkg::LOAD_ERM); // [R2]
    is_lra = (load_type_enable == haptic_drive_pkg::LOAD_LRA); // [R3]
    slow_tick = slow_osc_clock_in && !st_reg.osc_prev;
    // Register mode with rotating mass samples on the slow oscillator
    if (!drive_source_select) begin
      sample_evt = dec_evt; // [R4] [R5]
    end else if (is_erm) begin
      sample_evt = slow_tick; // [R6] [R7]
    end else begin
      sample_evt = dec_evt; // [R6] [R9]
    end
    // Squelch counts pulse periods, except rotating mass in register mode
    if (is_erm && drive_source_select) begin
      sq_evt = slow_tick; // [R10]
    end else begin
      sq_evt = dec_evt; // [R10] [R11]
    end
    in_squelch = abs8(st_reg.code) <= squelch_range;
    sq_active = st_reg.sq_cnt > haptic_drive_pkg::SQUELCH_LIMIT; // [R10] [R11]
    target = sq_active ? 8'h00 : st_reg.code;
  end

  // ==========================================================================
  // Slew filter: bandwidth picks the largest step per slow tick
  always_comb begin
    diff = {target[7], target} - {st_reg.level[7], st_reg.level};
    step = 9'h001 << slew_bandwidth; // [R12]
  end

  // ==========================================================================
  // APB decode; zero wait states, unmapped addresses answer with an error
  always_comb begin
    access = psel && penable;
    mapped = reg_hit(paddr);
  end

  // ==========================================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.osc_prev = slow_osc_clock_in;
    st_next.short_flag = short_detect_in; // [R14]

    // Register writes take effect in the access phase
    if (access && pwrite) begin
      if (paddr == haptic_drive_pkg::CTRL_OFFSET) begin
        st_next.ctrl = pwdata[15:0]; // [R13]
      end
      if (paddr == haptic_drive_pkg::AMP_OFFSET) begin
        st_next.amplitude = pwdata[7:0]; // [R13]
      end
    end

    // Read data captured in setup so it is stable for the access phase
    st_next.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        haptic_drive_pkg::CTRL_OFFSET: begin
          st_next.rdata = {16'h0000, st_reg.ctrl};
        end
        haptic_drive_pkg::AMP_OFFSET: begin
          st_next.rdata = {24'h000000, st_reg.amplitude};
        end
        haptic_drive_pkg::STATUS_OFFSET: begin
          st_next.rdata[haptic_drive_pkg::ST_SHORT_BIT] = st_reg.short_flag;
          st_next.rdata[haptic_drive_pkg::ST_SQ_BIT] = sq_active;
          st_next.rdata[haptic_drive_pkg::ST_CODE_LSB +: 8] = st_reg.code;
          st_next.rdata[haptic_drive_pkg::ST_LEVEL_LSB +: 8] = st_reg.dac;
        end
        default: begin
          st_next.rdata = 32'h0000_0000;
        end
      endcase
    end

    if (!enabled) begin
      // Disabled: flush history so re-enable starts from zero drive
      st_next.code = 8'h00; // [R1] [R15]
      st_next.sq_cnt = 10'h000;
      st_next.level = 8'h00;
      st_next.phase = 1'b0;
    end else begin
      if (sample_evt) begin
        st_next.code = drive_source_select ? st_reg.amplitude : dec_code; // [R4] [R6]
      end
      if (!in_squelch) begin
        st_next.sq_cnt = 10'h000; // [R10] [R11]
      end else if (sq_evt && !sq_active) begin
        st_next.sq_cnt = st_reg.sq_cnt + 10'h001; // [R10] [R11]
      end
      // Carrier flips every pulse period; only used for the resonant load
      if (is_lra && dec_evt) begin
        st_next.phase = !st_reg.phase; // [R3] [R9]
      end
      if (slow_tick) begin
        if (!diff[8] && diff > step) begin
          st_next.level = st_reg.level + step[7:0]; // [R12]
        end else if (diff[8] && (9'h000 - diff) > step) begin
          st_next.level = st_reg.level - step[7:0]; // [R12]
        end else begin
          st_next.level = target; // [R12]
        end
      end
    end

    // Output stage: envelope times carrier for the resonant load
    drive = (is_lra && st_reg.phase) ? (8'h00 - st_reg.level) : st_reg.level; // [R3]
    if (!enabled || st_reg.short_flag || !(is_erm || is_lra)) begin
      st_next.dac = 8'h00; // [R14] [R15]
      st_next.pos = 1'b0;
      st_next.neg = 1'b0;
    end else begin
      st_next.dac = drive; // [R2] [R12]
      st_next.pos = (drive != 8'h00) && !drive[7];
      st_next.neg = drive[7];
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '0;
      st_reg.ctrl <= haptic_drive_pkg::CTRL_RESET[15:0];
      st_reg.amplitude <= haptic_drive_pkg::AMP_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = access ? st_reg.rdata : 32'h0000_0000;
  assign dac_code_out = st_reg.dac;
  assign drive_out_pos_out = st_reg.pos;
  assign drive_out_neg_out = st_reg.neg;
  assign drive_gain_out = st_reg.ctrl[haptic_drive_pkg::GAIN_LSB +: 2]; // [R12]
  assign drive_range_out = st_reg.ctrl[haptic_drive_pkg::RANGE_BIT]; // [R8]
  assign driver_enable_out = enabled && !st_reg.short_flag; // [R1] [R14]
endmodule : haptic_motor_drive_control

// File: haptic_drive_pkg.sv
// Constants for the haptic actuator drive control block
// Operation
// [R1] Driver stays disabled while load type enable is zero, enabled otherwise.
// [R2] Load type enable 10 selects the rotating mass path with DC drive.
// [R3] Load type enable 01 selects the resonant path with carrier times envelope.
// [R4] Drive source select 0 takes the level from the pulse-width input.
// [R5] Pulse mode updates signed code each period: 0% -127, 50% 0, 100% +127.
// [R6] Drive source select 1 takes the level from the amplitude register.
// [R7] Host grounds the pulse input; register sampled on slow oscillator ticks.
// [R8] Host sets drive range to 1 in register mode with rotating mass load.
// [R9] Resonant register mode samples at pulse rate; carrier follows pulse input.
// [R10] Rotating mass: zero output after over 512 periods or ticks inside squelch.
// [R11] Resonant: zero envelope after over 512 carrier periods inside squelch.
// [R12] Level passes a bandwidth-selected slew filter into an 8-bit converter with gain.
// [R13] Host controls level in real time by pulse pin or register writes.
// [R14] Excess supply current sets short flag, grounds outputs, resumes when cleared.
// [R15] Both outputs held at zero drive while load type enable is zero.
// [R16] High time and period counted; duty ratio rounded to nearest code step.
package haptic_drive_pkg;
  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] AMP_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  // ==========================================================================
  // Control register fields
  localparam int LTE_LSB = 0;
  localparam int SRC_BIT = 2;
  localparam int RANGE_BIT = 3;
  localparam int BW_LSB = 4;
  localparam int GAIN_LSB = 6;
  localparam int SQ_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_FFFF;
  localparam logic [7:0] AMP_RESET = 8'h00;
  // ==========================================================================
  // Status register fields
  localparam int ST_SHORT_BIT = 0;
  localparam int ST_SQ_BIT = 1;
  localparam int ST_CODE_LSB = 8;
  localparam int ST_LEVEL_LSB = 16;
  // ==========================================================================
  // Load type encodings
  localparam logic [1:0] LOAD_OFF = 2'h0;
  localparam logic [1:0] LOAD_LRA = 2'h1;
  localparam logic [1:0] LOAD_ERM = 2'h2;
  // ==========================================================================
  // Timing and code constants
  localparam logic [9:0] SQUELCH_LIMIT = 10'h200;
  localparam logic [7:0] CODE_MAX = 8'h7F;
  localparam logic [31:0] CODE_SPAN = 32'h0000_00FE;
  localparam int CNT_W = 16;
endpackage : haptic_drive_pkg

// File: pwm_duty_decode.sv
// Duty-cycle decoder turning a pulse-width input into a signed level code
`timescale 1ns/1ps
module pwm_duty_decode (
  input wire logic mclk_in, // 10 MHz clock
  input wire logic rst_in, // async reset, active high
  input wire logic pwm_level_in, // pulse-width input
  output logic [7:0] code_out, // signed code, latest period
  output logic period_out // one-cycle pulse per period
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic prev;
    logic [haptic_drive_pkg::CNT_W-1:0] high_cnt;
    logic [haptic_drive_pkg::CNT_W-1:0] per_cnt;
    logic [7:0] code;
    logic evt;
  } dec_state_t;

  dec_state_t st_reg;
  dec_state_t st_next;
  logic [31:0] num;
  logic [31:0] den;
  logic [31:0] quo;

  // Rounded ratio: (2*span*high + period) / (2*period)
  always_comb begin
    num = haptic_drive_pkg::CODE_SPAN * 32'(st_reg.high_cnt) * 32'h2 + 32'(st_reg.per_cnt); // [R16]
    den = 32'(st_reg.per_cnt) * 32'h2;
    quo = (den == 32'h0) ? 32'h0 : num / den;
  end

  always_comb begin
    st_next = st_reg;
    st_next.prev = pwm_level_in;
    st_next.evt = 1'b0;
    if (pwm_level_in && !st_reg.prev) begin
      if (st_reg.per_cnt != '0) begin
        st_next.code = quo[7:0] - haptic_drive_pkg::CODE_MAX; // [R5]
        st_next.evt = 1'b1;
      end
      st_next.per_cnt = 16'h0001;
      st_next.high_cnt = 16'h0001;
    end else if (st_reg.per_cnt != 16'hFFFF) begin
      // Saturate on a stuck pin rather than wrap to a bogus ratio
      st_next.per_cnt = st_reg.per_cnt + 16'h0001; // [R16]
      st_next.high_cnt = st_reg.high_cnt + {15'h0000, pwm_level_in};
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign code_out = st_reg.code;
  assign period_out = st_reg.evt;
endmodule : pwm_duty_decode

// File: haptic_drive_properties.sv
// Port-level concurrent checks for the haptic drive control block
`timescale 1ns/1ps
module haptic_drive_checker (
  input wire logic mclk_in, // clock
  input wire logic rst_in, // async reset
  input wire logic psel, // APB select
  input wire logic penable, // APB access
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic short_detect_in, // over-current level
  input wire logic [7:0] dac_code_out, // converter code
  input wire logic drive_out_pos_out, // positive drive
  input wire logic drive_out_neg_out, // negative drive
  input wire logic [1:0] drive_gain_out, // gain select
  input wire logic drive_range_out, // range setting
  input wire logic driver_enable_out // driver enable
);
  // ====
  // Shadow of the control word, rebuilt from bus writes
  logic [15:0] ctrl_reg;
  logic mapped;
  assign mapped = paddr == haptic_drive_pkg::CTRL_OFFSET || paddr == haptic_drive_pkg::AMP_OFFSET ||
    paddr == haptic_drive_pkg::STATUS_OFFSET;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg <= 16'h0000;
    end else if (psel && penable && pwrite && pready && paddr == haptic_drive_pkg::CTRL_OFFSET) begin
      ctrl_reg <= pwdata[15:0];
    end
  end
  // ====
  // Properties
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence s_short_held; short_detect_in [*3]; endsequence
  sequence s_off_held; (ctrl_reg[1:0] == 2'h0) [*3]; endsequence
  property p_off_enable; ctrl_reg[1:0] == 2'h0 |-> !driver_enable_out; endproperty
  property p_on_enable;
    ctrl_reg[1:0] != 2'h0 && !short_detect_in && !$past(short_detect_in) |-> driver_enable_out;
  endproperty
  property p_off_outputs;
    s_off_held |-> !drive_out_pos_out && !drive_out_neg_out && dac_code_out == 8'h00;
  endproperty
  property p_short_stop; s_short_held |-> !drive_out_pos_out && !drive_out_neg_out && !driver_enable_out; endproperty
  property p_pos_sign; drive_out_pos_out |-> !drive_out_neg_out && !dac_code_out[7] && dac_code_out != 8'h00; endproperty
  property p_neg_sign; drive_out_neg_out |-> dac_code_out[7]; endproperty
  property p_code_range; dac_code_out != 8'h80; endproperty
  property p_reg_out; drive_gain_out == ctrl_reg[7:6] && drive_range_out == ctrl_reg[3]; endproperty
  property p_unmapped; psel && penable && !mapped |-> pslverr && prdata == 32'h0000_0000; endproperty
  property p_mapped; psel && penable && mapped |-> pready && !pslverr; endproperty
  a_off_enable: assert property (p_off_enable) else $error("Driver enabled while load type off");
  a_on_enable: assert property (p_on_enable) else $error("Driver not enabled");
  a_off_outputs: assert property (p_off_outputs) else $error("Outputs not zero while off");
  a_short_stop: assert property (p_short_stop) else $error("Outputs live during short");
  a_pos_sign: assert property (p_pos_sign) else $error("Positive drive with bad code");
  a_neg_sign: assert property (p_neg_sign) else $error("Negative drive with bad code");
  a_code_range: assert property (p_code_range) else $error("Code outside signed range");
  a_reg_out: assert property (p_reg_out) else $error("Gain or range differs from control");
  a_unmapped: assert property (p_unmapped) else $error("Unmapped access not refused");
  a_mapped: assert property (p_mapped) else $error("Mapped access refused");
endmodule : haptic_drive_checker

// File: haptic_pwm_host.sv
// Host-side model driving the pulse-width pin
`timescale 1ns/1ps
module haptic_pwm_host (
  input wire logic mclk_in, // clock
  input wire logic rst_in, // async reset
  input wire logic run_in, // pulses when high
  input wire logic [15:0] high_in, // high time in cycles
  input wire logic [15:0] period_in, // period in cycles
  output logic pwm_out // pulse-width pin
);
  logic [15:0] cnt_reg;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= 16'h0000;
      pwm_out <= 1'b0;
    end else if (!run_in) begin
      cnt_reg <= 16'h0000;
      pwm_out <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg + 16'h0001 >= period_in) ? 16'h0000 : cnt_reg + 16'h0001;
      pwm_out <= cnt_reg < high_in;
    end
  end
endmodule : haptic_pwm_host

// File: test_haptic_motor_drive_control.sv
// Self-checking bench for the haptic drive control block
`timescale 1ns/1ps
module test_haptic_motor_drive_control;
  logic mclk_in, rst_in, psel, penable, pwrite, pwm_level_in, slow_osc_clock_in, short_detect_in;
  logic pready, pslverr, drive_out_pos_out, drive_out_neg_out, drive_range_out, driver_enable_out, err, run;
  logic [7:0] paddr, dac_code_out;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] drive_gain_out;
  logic [15:0] high, per;
  integer mismatches = 0, checks_done = 0, seed = 10266, amp, i, seen_p, seen_n;
  // ====
  // Design and host pin model
  haptic_motor_drive_control i_haptic_motor_drive_control (.*);
  haptic_pwm_host i_haptic_pwm_host (.mclk_in, .rst_in, .run_in(run), .high_in(high), .period_in(per),
    .pwm_out(pwm_level_in));
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  // Slow oscillator: one tick every 4 clocks keeps squelch runs short
  always begin
    repeat (2) @(posedge mclk_in);
    slow_osc_clock_in <= ~slow_osc_clock_in;
  end
  // ====
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    @(posedge mclk_in);
    // Only the watchdog ends a wait for ready
    while (pready !== 1'b1) begin
      @(posedge mclk_in);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never re-drives psel in this time step
    @(posedge mclk_in);
  endtask : apb
  function automatic integer ecode(input integer h, input integer p);
    return (508 * h + p) / (2 * p) - 127;
  endfunction : ecode
  task automatic print_verdict;
    if (mismatches == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  // ====
  // Scenarios
  initial begin
    {rst_in, psel, penable, pwrite, slow_osc_clock_in, short_detect_in, run} = 7'h40;
    paddr = 8'h00;
    pwdata = 32'h0;
    high = 16'h0;
    per = 16'd254;
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    apb(1'b0, haptic_drive_pkg::CTRL_OFFSET, 32'h0);
    chk(rd, haptic_drive_pkg::CTRL_RESET);
    chk(driver_enable_out, 1'b0);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    chk(err, 1'b1);
    apb(1'b1, haptic_drive_pkg::CTRL_OFFSET, 32'h0000_00B2);
    run <= 1'b1;
    for (i = 0; i < 4; i++) begin
      high <= 16'(1 + $unsigned($random(seed)) % 253);
      repeat (772) @(posedge mclk_in);
      amp = ecode(high, 254);
      apb(1'b0, haptic_drive_pkg::STATUS_OFFSET, 32'h0);
      chk(rd[15:8], amp[7:0]);
      chk(dac_code_out, amp[7:0]);
      chk(drive_out_pos_out, amp > 0);
    end
    run <= 1'b0;
    apb(1'b1, haptic_drive_pkg::CTRL_OFFSET, 32'hFFFF_00BE);
    apb(1'b0, haptic_drive_pkg::CTRL_OFFSET, 32'h0);
    chk(rd, 32'h0000_00BE);
    chk({drive_gain_out, drive_range_out}, 3'h5);
    amp = 20 + $unsigned($random(seed)) % 100;
    if ($random(seed) & 1) amp = -amp;
    apb(1'b1, haptic_drive_pkg::AMP_OFFSET, amp);
    apb(1'b0, haptic_drive_pkg::AMP_OFFSET, 32'h0);
    chk(rd, {24'h0, amp[7:0]});
    repeat (200) @(posedge mclk_in);
    apb(1'b0, haptic_drive_pkg::STATUS_OFFSET, 32'h0);
    chk(rd[15:8], amp[7:0]);
    chk(dac_code_out, amp[7:0]);
    apb(1'b1, haptic_drive_pkg::CTRL_OFFSET, 32'h0000_10BE);
    apb(1'b1, haptic_drive_pkg::AMP_OFFSET, 32'h5);
    repeat (1800) @(posedge mclk_in);
    chk(dac_code_out, 8'h05);
    repeat (400) @(posedge mclk_in);
    apb(1'b0, haptic_drive_pkg::STATUS_OFFSET, 32'h0);
    chk({rd[1], dac_code_out}, 9'h100);
    high <= 16'd127;
    run <= 1'b1;
    apb(1'b1, haptic_drive_pkg::CTRL_OFFSET, 32'h0000_00B5);
    apb(1'b1, haptic_drive_pkg::AMP_OFFSET, 32'd40);
    repeat (1000) @(posedge mclk_in);
    seen_p = 0;
    seen_n = 0;
    repeat (600) begin
      @(posedge mclk_in);
      seen_p += (dac_code_out === 8'h28);
      seen_n += (dac_code_out === 8'hD8);
    end
    chk(seen_p > 0 && seen_n > 0 && seen_p + seen_n == 600, 1'b1);
    short_detect_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    chk({drive_out_pos_out, drive_out_neg_out, driver_enable_out}, 3'h0);
    apb(1'b0, haptic_drive_pkg::STATUS_OFFSET, 32'h0);
    chk(rd[0], 1'b1);
    short_detect_in <= 1'b0;
    repeat (600) @(posedge mclk_in);
    apb(1'b0, haptic_drive_pkg::STATUS_OFFSET, 32'h0);
    chk({rd[0], driver_enable_out}, 2'h1);
    apb(1'b1, haptic_drive_pkg::CTRL_OFFSET, 32'h0);
    repeat (3) @(posedge mclk_in);
    chk({dac_code_out, drive_out_pos_out, drive_out_neg_out, driver_enable_out}, 11'h0);
    print_verdict();
  end
  // Watchdog well beyond the roughly 7800 cycles the scenarios need
  initial begin
    repeat (30000) @(posedge mclk_in);
    mismatches++;
    print_verdict();
  end
endmodule : test_haptic_motor_drive_control
bind haptic_motor_drive_control haptic_drive_checker i_haptic_drive_checker (.*);
